// file: gpio_bank_pkg.sv
// Function
// - Input-mode reads return pin, output-mode latch
// - Writes always load latch; latch drives outputs
// - Peripheral output drives pin regardless direction
// - Unimplemented direction bits read zero
// - Unimplemented data bits read zero
// - Group-0 direction writable only right after unlock
// - Group-4 pins 3,4 only without sub-clock
// - Pull-ups act only on input-mode pins
// - Control-0 bits pull up four pins each
// - Control-1 governs group 4 and 6 pull-ups
// - Control-0 bit 1: group-0 pins 4-7
// - Control-0 bit 2: group-1 pins 0-3
// - Group-0 pin 6 feeds external irq 4
// - Group-0 pin 7 feeds key input 0
// - Group-1 pin 0: timer out, key, comparator
package gpio_bank_pkg;

	////////////////////////////////////////////////////////////////
	// Bank shape; index 0..4 stands for groups 0,1,3,4,6
	localparam int NUM_GROUPS = 5;
	typedef logic [NUM_GROUPS-1:0][7:0] port_bus_t;

	// Implemented pins per group
	localparam port_bus_t IMPL_MASK = {8'h79, 8'h38, 8'hff, 8'hff, 8'hf0};
	// Group-4 pins lost to the sub-clock oscillator
	localparam logic [7:0] SUBCLK_MASK = 8'h18;

	////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam port_bus_t DATA_OFF = {8'h10, 8'h0c, 8'h08, 8'h04, 8'h00};
	localparam port_bus_t DIR_OFF  = {8'h24, 8'h20, 8'h1c, 8'h18, 8'h14};
	localparam logic [7:0] PU0_OFF  = 8'h28;
	localparam logic [7:0] PU1_OFF  = 8'h2c;
	localparam logic [7:0] PROT_OFF = 8'h30;
	localparam logic [7:0] FUNC_OFF = 8'h34;

	////////////////////////////////////////////////////////////////
	// Field positions and writable masks
	localparam int UNLOCK_BIT  = 2;
	localparam int PU_G0_HI    = 1;
	localparam int PU_G1_LO    = 2;
	localparam int PU_G1_HI    = 3;
	localparam int PU_G3_LO    = 4;
	localparam int PU_G3_HI    = 5;
	localparam int PU_P4_3     = 0;
	localparam int PU_P4_5     = 1;
	localparam int PU_P6_03    = 2;
	localparam int PU_P6_46    = 3;
	localparam int FN_IRQ4_EN  = 0;
	localparam int FN_KEY0_SEL = 1;
	localparam int FN_KEY0_EN  = 2;
	localparam int FN_TMR0_EN  = 3;
	localparam int FN_CMP1_SEL = 4;
	localparam logic [7:0] PU0_MASK  = 8'h3e;
	localparam logic [7:0] PU1_MASK  = 8'h0f;
	localparam logic [7:0] FUNC_MASK = 8'h1f;
	localparam logic [7:0] RST_BYTE  = 8'h00;

	////////////////////////////////////////////////////////////////
	// Classic bus request carrier
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

endpackage : gpio_bank_pkg

// file: gpio_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the bank; sees only the top module's ports
module gpio_bank_props (
	input wire logic                     ref_clk,
	input wire logic                     reset_n,
	input wire gpio_bank_pkg::wb_req_s   wb_req,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     wb_ack_o,
	input wire gpio_bank_pkg::port_bus_t pins_i,
	input wire gpio_bank_pkg::port_bus_t pins_o,
	input wire gpio_bank_pkg::port_bus_t pins_oe_n,
	input wire gpio_bank_pkg::port_bus_t pullup_o,
	input wire logic                     subclock_osc_used,
	input wire logic                     timer_output_0,
	input wire logic                     ext_irq4_input,
	input wire logic                     key_input_0,
	input wire logic                     comparator1_input
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	logic [7:0] fn_reg; // Shadow of the function selects
	logic       rd_ack; // Read answered in this cycle
	assign rd_ack = wb_ack_o && !wb_req.we;
	// Shadow loads at the edge where a write commits
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fn_reg <= 8'h00;
		end else if (wb_ack_o && wb_req.we && wb_req.sel[0] && wb_req.adr == gpio_bank_pkg::FUNC_OFF) begin
			fn_reg <= wb_req.dat[7:0] & gpio_bank_pkg::FUNC_MASK;
		end
	end
	sequence s_req; wb_req.cyc && wb_req.stb && !wb_ack_o; endsequence
	sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
	////////////////////////////////////////////////////////////////
	AST_ACK: assert property (s_req |=> s_pulse)
		else $error("ack is not a single pulse one cycle after request");
	AST_DIR0_LOW: assert property (rd_ack && wb_req.adr == 8'h14 |-> wb_dat_o[3:0] == 4'h0)
		else $error("unimplemented direction bits read nonzero");
	AST_DATA4_LOW: assert property (rd_ack && wb_req.adr == 8'h0c |-> (wb_dat_o[7:0] & 8'hc7) == 8'h00)
		else $error("unimplemented data bits read nonzero");
	AST_NO_DRIVE: assert property (&(pins_oe_n | gpio_bank_pkg::IMPL_MASK))
		else $error("absent pin driven");
	AST_PULL_IN: assert property ((pullup_o & ~pins_oe_n) == 40'h0)
		else $error("pull-up on a driven pin");
	AST_SUBCLK: assert property (subclock_osc_used && $past(subclock_osc_used)
		|-> pins_oe_n[3][4:3] == 2'h3 && pullup_o[3][4:3] == 2'h0) else $error("sub-clock pins in use");
	AST_TIMER: assert property ($past(fn_reg[3]) |-> !pins_oe_n[1][0]
		&& pins_o[1][0] == $past(timer_output_0)) else $error("timer output not on pin");
	AST_IRQ4: assert property (ext_irq4_input == ($past(fn_reg[0])
		&& pins_oe_n[0][6] && $past(pins_i[0][6]))) else $error("irq4 feed wrong");
	AST_KEY: assert property (key_input_0 == ($past(fn_reg[2]) && ($past(fn_reg[1]) ?
		pins_oe_n[0][7] && $past(pins_i[0][7]) : pins_oe_n[1][0] && $past(pins_i[1][0])))) else $error("key feed wrong");
	AST_CMP: assert property (comparator1_input == ($past(fn_reg[4])
		&& pins_oe_n[1][0] && $past(pins_i[1][0]))) else $error("comparator feed wrong");
	AST_RST: assert property (!$past(reset_n) |-> &pins_oe_n && pullup_o == 40'h0)
		else $error("pins not idle after reset");
endmodule : gpio_bank_props
`default_nettype wire

// file: gpio_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board side: device drive wins, then bench drivers, then pull-ups
module gpio_board (
	input  wire logic                     ref_clk,
	input  wire gpio_bank_pkg::port_bus_t pins_o,
	input  wire gpio_bank_pkg::port_bus_t pins_oe_n,
	input  wire gpio_bank_pkg::port_bus_t pullup_o,
	input  wire gpio_bank_pkg::port_bus_t ext_val,
	input  wire gpio_bank_pkg::port_bus_t ext_en,
	output var gpio_bank_pkg::port_bus_t  pins_i
);
	logic [39:0] noise = 40'h5555555555; // Floating pins never settle
	always @(posedge ref_clk) noise <= ~noise;
	// Pull level only on released, undriven pins
	assign pins_i = (~pins_oe_n & pins_o) | (pins_oe_n & ext_en & ext_val)
		| (pins_oe_n & ~ext_en & (pullup_o | noise));
endmodule : gpio_board
`default_nettype wire

// file: gpio_pin_group.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_group (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] avail_mask,
	input  wire logic [7:0] dir_bits,
	input  wire logic [7:0] latch_bits,
	input  wire logic [7:0] pin_i,
	input  wire logic [7:0] periph_oe,
	input  wire logic [7:0] periph_val,
	input  wire logic [7:0] pull_req,
	output logic      [7:0] read_val,
	output logic      [7:0] pin_o,
	output logic      [7:0] pin_oe_n,
	output logic      [7:0] pullup_o
);

	////////////////////////////////////////////////////////////////
	// Drive and pull state for the next cycle
	logic [7:0] drive_next; // Pins actively driven
	logic [7:0] val_next;   // Level put on driven pins
	logic [7:0] pull_next;  // Pull-ups to connect

	// Reads mix pin and latch per direction
	always_comb begin
		read_val = avail_mask & ((dir_bits & latch_bits) | (~dir_bits & pin_i));
	end

	// Peripheral output wins over the port latch
	always_comb begin
		drive_next = avail_mask & (periph_oe | dir_bits);
		val_next   = avail_mask & ((periph_oe & periph_val) | (~periph_oe & latch_bits));
		pull_next  = avail_mask & pull_req & ~dir_bits & ~periph_oe;
	end

	// Registered pad controls, released at reset
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_o    <= 8'h00;
			pin_oe_n <= 8'hff;
			pullup_o <= 8'h00;
		end else begin
			pin_o    <= val_next;
			pin_oe_n <= ~drive_next;
			pullup_o <= pull_next;
		end
	end

endmodule : gpio_pin_group
`default_nettype wire

// file: gpio_port_bank.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bank (
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	input  wire gpio_bank_pkg::wb_req_s  wb_req,
	output logic [31:0]                  wb_dat_o,
	output logic                         wb_ack_o,
	input  wire gpio_bank_pkg::port_bus_t pins_i,
	output gpio_bank_pkg::port_bus_t     pins_o,
	output gpio_bank_pkg::port_bus_t     pins_oe_n,
	output gpio_bank_pkg::port_bus_t     pullup_o,
	input  wire logic                    subclock_osc_used,
	input  wire logic                    timer_output_0,
	output logic                         ext_irq4_input,
	output logic                         key_input_0,
	output logic                         comparator1_input
);

	////////////////////////////////////////////////////////////////
	// Shared helpers

	// Byte write keeping only writable bits
	function automatic logic [7:0] masked_write(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic [7:0] mask
	);
		masked_write = (old_val & ~mask) | (new_val & mask);
	endfunction : masked_write

	////////////////////////////////////////////////////////////////
	// Register state
	gpio_bank_pkg::port_bus_t data_reg;      // Port latches
	gpio_bank_pkg::port_bus_t dir_reg;       // Direction bits
	logic [7:0]               pu0_reg;       // pullup_control_0
	logic [7:0]               pu1_reg;       // pullup_control_1
	logic [7:0]               func_reg;      // Pin function selects
	logic                     unlock_reg;    // dir0_write_unlock_bit
	logic                     ack_reg;       // Bus acknowledge
	logic [31:0]              rdata_reg;     // Captured read data
	logic                     irq4_reg;      // Interrupt-4 feed
	logic                     key0_reg;      // Key-0 feed
	logic                     cmp1_reg;      // Comparator-1 feed

	////////////////////////////////////////////////////////////////
	// Combinational helpers
	gpio_bank_pkg::port_bus_t avail;         // Usable pins now
	gpio_bank_pkg::port_bus_t read_val;      // Per-group read value
	gpio_bank_pkg::port_bus_t pull_req;      // Per-pin pull request
	gpio_bank_pkg::port_bus_t periph_oe;     // Peripheral drive enable
	gpio_bank_pkg::port_bus_t periph_val;    // Peripheral drive level
	logic                     bus_req;       // Request present
	logic                     wr_fire;       // Write commits this edge
	logic                     acc_done;      // Any access completes
	logic                     lane0;         // Low byte enabled
	logic [7:0]               rbyte_next;    // Decoded read byte

	assign bus_req  = wb_req.cyc & wb_req.stb;
	assign acc_done = bus_req & ack_reg;
	assign wr_fire  = acc_done & wb_req.we;
	assign lane0    = wb_req.sel[0];

	////////////////////////////////////////////////////////////////
	// Pin availability

	// Sub-clock use takes group-4 pins 3 and 4 away
	always_comb begin
		avail = gpio_bank_pkg::IMPL_MASK;
		if (subclock_osc_used) begin
			avail[3] = gpio_bank_pkg::IMPL_MASK[3] & ~gpio_bank_pkg::SUBCLK_MASK;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pull-up fan-out; pins are grouped, except pins 4_3 and 4_5 with a bit each
	always_comb begin
		pull_req    = '0;
		pull_req[0] = {{4{pu0_reg[gpio_bank_pkg::PU_G0_HI]}}, 4'h0};
		pull_req[1] = {{4{pu0_reg[gpio_bank_pkg::PU_G1_HI]}},
			{4{pu0_reg[gpio_bank_pkg::PU_G1_LO]}}};
		pull_req[2] = {{4{pu0_reg[gpio_bank_pkg::PU_G3_HI]}},
			{4{pu0_reg[gpio_bank_pkg::PU_G3_LO]}}};
		// Pin 4_4 has no pull-up at all
		pull_req[3][3] = pu1_reg[gpio_bank_pkg::PU_P4_3];
		pull_req[3][5] = pu1_reg[gpio_bank_pkg::PU_P4_5];
		pull_req[4][0] = pu1_reg[gpio_bank_pkg::PU_P6_03];
		pull_req[4][3] = pu1_reg[gpio_bank_pkg::PU_P6_03];
		pull_req[4][6:4] = {3{pu1_reg[gpio_bank_pkg::PU_P6_46]}};
	end

	////////////////////////////////////////////////////////////////
	// Peripheral output overrides
	always_comb begin
		periph_oe     = '0;
		periph_val    = '0;
		// Timer output ignores the direction bit
		periph_oe[1][0]  = func_reg[gpio_bank_pkg::FN_TMR0_EN];
		periph_val[1][0] = timer_output_0;
	end

	////////////////////////////////////////////////////////////////
	// One pad group per port
	for (genvar g = 0; g < gpio_bank_pkg::NUM_GROUPS; g++) begin : g_grp
		gpio_pin_group u_grp (
			.ref_clk    (ref_clk),
			.reset_n    (reset_n),
			.avail_mask (avail[g]),
			.dir_bits   (dir_reg[g]),
			.latch_bits (data_reg[g]),
			.pin_i      (pins_i[g]),
			.periph_oe  (periph_oe[g]),
			.periph_val (periph_val[g]),
			.pull_req   (pull_req[g]),
			.read_val   (read_val[g]),
			.pin_o      (pins_o[g]),
			.pin_oe_n   (pins_oe_n[g]),
			.pullup_o   (pullup_o[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// Read decode; unmapped offsets answer zero
	always_comb begin
		rbyte_next = 8'h00;
		if (wb_req.adr == gpio_bank_pkg::DATA_OFF[0]) begin
			rbyte_next = read_val[0];
		end else if (wb_req.adr == gpio_bank_pkg::DATA_OFF[1]) begin
			rbyte_next = read_val[1];
		end else if (wb_req.adr == gpio_bank_pkg::DATA_OFF[2]) begin
			rbyte_next = read_val[2];
		end else if (wb_req.adr == gpio_bank_pkg::DATA_OFF[3]) begin
			rbyte_next = read_val[3];
		end else if (wb_req.adr == gpio_bank_pkg::DATA_OFF[4]) begin
			rbyte_next = read_val[4];
		end else if (wb_req.adr == gpio_bank_pkg::DIR_OFF[0]) begin
			rbyte_next = dir_reg[0];
		end else if (wb_req.adr == gpio_bank_pkg::DIR_OFF[1]) begin
			rbyte_next = dir_reg[1];
		end else if (wb_req.adr == gpio_bank_pkg::DIR_OFF[2]) begin
			rbyte_next = dir_reg[2];
		end else if (wb_req.adr == gpio_bank_pkg::DIR_OFF[3]) begin
			rbyte_next = dir_reg[3];
		end else if (wb_req.adr == gpio_bank_pkg::DIR_OFF[4]) begin
			rbyte_next = dir_reg[4];
		end else if (wb_req.adr == gpio_bank_pkg::PU0_OFF) begin
			rbyte_next = pu0_reg;
		end else if (wb_req.adr == gpio_bank_pkg::PU1_OFF) begin
			rbyte_next = pu1_reg;
		end else if (wb_req.adr == gpio_bank_pkg::PROT_OFF) begin
			rbyte_next = {5'h00, unlock_reg, 2'h0};
		end else if (wb_req.adr == gpio_bank_pkg::FUNC_OFF) begin
			rbyte_next = func_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus handshake: ack one cycle after the request, dropped next
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
		end
	end

	// Read data captured as ack rises, held while ack stands
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus_req && !ack_reg) begin
			rdata_reg <= {24'h00_0000, rbyte_next};
		end
	end

	////////////////////////////////////////////////////////////////
	// Port latches; written in any direction mode
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			data_reg <= '0;
		end else if (wr_fire && lane0) begin
			for (int g = 0; g < gpio_bank_pkg::NUM_GROUPS; g++) begin
				if (wb_req.adr == gpio_bank_pkg::DATA_OFF[g]) begin
					data_reg[g] <= masked_write(data_reg[g], wb_req.dat[7:0],
						gpio_bank_pkg::IMPL_MASK[g]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Direction bits; group 0 only while unlocked
	// Pin 4_4 has no pull-up, so software keeps it at 1
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dir_reg <= '0;
		end else if (wr_fire && lane0) begin
			for (int g = 0; g < gpio_bank_pkg::NUM_GROUPS; g++) begin
				if ((wb_req.adr == gpio_bank_pkg::DIR_OFF[g]) && ((g != 0) || unlock_reg)) begin
					dir_reg[g] <= masked_write(dir_reg[g], wb_req.dat[7:0],
						gpio_bank_pkg::IMPL_MASK[g]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Unlock lives for exactly one following access
	// A write that sets the bit wins over the clear it would cause
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			unlock_reg <= 1'b0;
		end else if (acc_done) begin
			if (wb_req.we && lane0 && (wb_req.adr == gpio_bank_pkg::PROT_OFF)) begin
				unlock_reg <= wb_req.dat[gpio_bank_pkg::UNLOCK_BIT];
			end else begin
				unlock_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Pull-up and function selects
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pu0_reg  <= gpio_bank_pkg::RST_BYTE;
			pu1_reg  <= gpio_bank_pkg::RST_BYTE;
			func_reg <= gpio_bank_pkg::RST_BYTE;
		end else if (wr_fire && lane0) begin
			if (wb_req.adr == gpio_bank_pkg::PU0_OFF) begin
				pu0_reg <= masked_write(pu0_reg, wb_req.dat[7:0], gpio_bank_pkg::PU0_MASK);
			end else if (wb_req.adr == gpio_bank_pkg::PU1_OFF) begin
				pu1_reg <= masked_write(pu1_reg, wb_req.dat[7:0], gpio_bank_pkg::PU1_MASK);
			end else if (wb_req.adr == gpio_bank_pkg::FUNC_OFF) begin
				func_reg <= masked_write(func_reg, wb_req.dat[7:0], gpio_bank_pkg::FUNC_MASK);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Peripheral input feeds; a pin in output mode feeds nothing
	// Inputs need direction 0, which reset already loads
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			irq4_reg <= 1'b0;
			key0_reg <= 1'b0;
			cmp1_reg <= 1'b0;
		end else begin
			irq4_reg <= func_reg[gpio_bank_pkg::FN_IRQ4_EN] & ~dir_reg[0][6]
				& pins_i[0][6];
			if (func_reg[gpio_bank_pkg::FN_KEY0_EN]) begin
				if (func_reg[gpio_bank_pkg::FN_KEY0_SEL]) begin
					key0_reg <= ~dir_reg[0][7] & pins_i[0][7];
				end else begin
					key0_reg <= ~dir_reg[1][0] & pins_i[1][0];
				end
			end else begin
				key0_reg <= 1'b0;
			end
			cmp1_reg <= func_reg[gpio_bank_pkg::FN_CMP1_SEL] & ~dir_reg[1][0]
				& pins_i[1][0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_ack_o          = ack_reg;
	assign wb_dat_o          = rdata_reg;
	assign ext_irq4_input    = irq4_reg;
	assign key_input_0       = key0_reg;
	assign comparator1_input = cmp1_reg;

endmodule : gpio_port_bank
`default_nettype wire

// file: gpio_port_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bank_test;
	logic                      ref_clk, reset_n, subclock_osc_used, timer_output_0;
	gpio_bank_pkg::wb_req_s    wb_req;
	logic [31:0]               wb_dat_o;
	logic                      wb_ack_o, ext_irq4_input, key_input_0, comparator1_input;
	gpio_bank_pkg::port_bus_t  pins_i, pins_o, pins_oe_n, pullup_o, ext_val, ext_en;
	int                        error_cnt, num_checks, cycles;
	logic [7:0]                q; // Last read data
	gpio_port_bank gpio_port_bank_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i), .pins_o(pins_o), .pins_oe_n(pins_oe_n),
		.pullup_o(pullup_o), .subclock_osc_used(subclock_osc_used), .timer_output_0(timer_output_0),
		.ext_irq4_input(ext_irq4_input), .key_input_0(key_input_0), .comparator1_input(comparator1_input));
	gpio_board gpio_board_inst (.ref_clk(ref_clk), .pins_o(pins_o), .pins_oe_n(pins_oe_n),
		.pullup_o(pullup_o), .ext_val(ext_val), .ext_en(ext_en), .pins_i(pins_i));
	always #2.5 ref_clk = ~ref_clk;
	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			error_cnt++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Classic single cycle; held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		wb_req <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
		do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
		q = wb_dat_o[7:0];
		wb_req <= '0;
		@(posedge ref_clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(1'h1, a, d); endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk($sformatf("reg %h", a), q, e);
	endtask : rc
	// Pins follow a register one edge after the write
	task automatic settle; repeat (2) @(posedge ref_clk); endtask : settle
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 5; i++) rc(gpio_bank_pkg::DIR_OFF[i], 8'h00);
		rc(gpio_bank_pkg::PU0_OFF, 8'h00);
		rc(gpio_bank_pkg::PU1_OFF, 8'h00);
		// Two compares: one 80-bit concatenation would lose the enables to the 40-bit argument
		chk("idle oe_n", pins_oe_n, 40'hffffffffff);
		chk("idle pull", pullup_o, 40'h0);
	endtask : t_reset
	task automatic t_pull;
		logic [15:0] t1 [4] = '{16'h0308, 16'h0320, 16'h0409, 16'h0470};
		logic [39:0] e;
		for (int b = 1; b < 6; b++) begin
			wr(gpio_bank_pkg::PU0_OFF, 8'h01 << b);
			settle();
			e = '0;
			e[b/2*8 +: 8] = b % 2 ? 8'hf0 : 8'h0f;
			chk("pull ctl0", pullup_o, e);
		end
		wr(gpio_bank_pkg::PU0_OFF, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(gpio_bank_pkg::PU1_OFF, 1 << k);
			settle();
			e = '0;
			e[t1[k][15:8]*8 +: 8] = t1[k][7:0];
			chk("pull ctl1", pullup_o, e);
		end
		wr(gpio_bank_pkg::PU0_OFF, 8'h3e);
		wr(gpio_bank_pkg::PU1_OFF, 8'h0f);
		subclock_osc_used <= 1'h1;
		settle();
		chk("pull all", pullup_o, {8'h79, 8'h20, 8'hff, 8'hff, 8'hf0});
		subclock_osc_used <= 1'h0;
	endtask : t_pull
	task automatic t_port;
		wr(gpio_bank_pkg::DIR_OFF[1], 8'h0f);
		ext_en[1] <= 8'hf0;
		ext_val[1] <= 8'hc0;
		wr(gpio_bank_pkg::DATA_OFF[1], 8'ha5);
		settle();
		chk("g1 drive", {pins_oe_n[1], pins_o[1][3:0]}, {8'hf0, 4'h5});
		chk("g1 pull", pullup_o[1], 8'hf0);
		rc(gpio_bank_pkg::DATA_OFF[1], 8'hc5);
		wr(gpio_bank_pkg::DIR_OFF[1], 8'h00);
		wr(gpio_bank_pkg::DATA_OFF[1], 8'h3c);
		ext_en[1] <= 8'h00;
		wr(gpio_bank_pkg::DIR_OFF[1], 8'hff);
		settle();
		chk("g1 latch", pins_o[1], 8'h3c);
		rc(gpio_bank_pkg::DATA_OFF[1], 8'h3c);
		wr(gpio_bank_pkg::DIR_OFF[1], 8'h00);
	endtask : t_port
	// Unlock, stray access, reserved bits, unmapped address
	task automatic t_unimpl;
		wr(gpio_bank_pkg::DIR_OFF[0], 8'hff);
		rc(gpio_bank_pkg::DIR_OFF[0], 8'h00);
		wr(gpio_bank_pkg::PROT_OFF, 8'h04);
		rc(8'h3c, 8'h00);
		wr(gpio_bank_pkg::DIR_OFF[0], 8'hff);
		rc(gpio_bank_pkg::DIR_OFF[0], 8'h00);
		wr(gpio_bank_pkg::PROT_OFF, 8'h04);
		wr(gpio_bank_pkg::DIR_OFF[0], 8'hff);
		wr(gpio_bank_pkg::DIR_OFF[0], 8'h00);
		rc(gpio_bank_pkg::DIR_OFF[0], 8'hf0);
		for (int i = 3; i < 5; i++) begin
			wr(gpio_bank_pkg::DIR_OFF[i], 8'hff);
			wr(gpio_bank_pkg::DATA_OFF[i], 8'hff);
			rc(gpio_bank_pkg::DIR_OFF[i], gpio_bank_pkg::IMPL_MASK[i]);
			rc(gpio_bank_pkg::DATA_OFF[i], gpio_bank_pkg::IMPL_MASK[i]);
		end
		wr(gpio_bank_pkg::PROT_OFF, 8'h04);
		wr(gpio_bank_pkg::DIR_OFF[0], 8'h00);
	endtask : t_unimpl
	task automatic t_periph;
		logic [7:0] fs [4] = '{8'h01, 8'h06, 8'h04, 8'h10};
		logic [2:0] e1 [4] = '{3'h4, 3'h2, 3'h0, 3'h0};
		logic [2:0] e0 [4] = '{3'h0, 3'h0, 3'h2, 3'h1};
		wr(gpio_bank_pkg::FUNC_OFF, 8'h08);
		for (int v = 0; v < 2; v++) begin
			timer_output_0 <= v[0];
			settle();
			chk("timer pin", {pins_oe_n[1][0], pins_o[1][0]}, {1'h0, v[0]});
		end
		ext_en[0] <= 8'hc0;
		ext_en[1] <= 8'h01;
		for (int k = 0; k < 4; k++) begin
			wr(gpio_bank_pkg::FUNC_OFF, fs[k]);
			for (int v = 0; v < 2; v++) begin
				ext_val[0] <= {8{v[0]}};
				ext_val[1] <= {8{~v[0]}};
				settle();
				chk("feeds", {ext_irq4_input, key_input_0, comparator1_input}, v ? e1[k] : e0[k]);
			end
		end
	endtask : t_periph
	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		{ref_clk, reset_n, subclock_osc_used, timer_output_0} = 4'h0;
		{wb_req, ext_val, ext_en} = '0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		t_reset();
		t_pull();
		t_port();
		t_unimpl();
		t_periph();
		end_sim();
	end
endmodule : gpio_port_bank_test
bind gpio_port_bank gpio_bank_props gpio_bank_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
	.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i), .pins_o(pins_o),
	.pins_oe_n(pins_oe_n), .pullup_o(pullup_o), .subclock_osc_used(subclock_osc_used),
	.timer_output_0(timer_output_0), .ext_irq4_input(ext_irq4_input), .key_input_0(key_input_0),
	.comparator1_input(comparator1_input));
`default_nettype wire
